// File: inc/headset_detect_cfg.svh
// Purpose: offsets, field positions, reset values and timing counts for headset detection
// Assumes: 40 MHz control clock
// Notes:   definitions only
`ifndef HEADSET_DETECT_CFG_SVH
`define HEADSET_DETECT_CFG_SVH

// register offsets
`define ADDR_SENSE_CFG    8'h1a
`define ADDR_DEBOUNCE_CFG 8'h1b
`define ADDR_STATUS       8'h1c

// reset values
`define RST_SENSE_CFG     8'h00
`define RST_DEBOUNCE_CFG  8'h00

// writable bits; reserved bits are masked so they read as zero
`define WMASK_SENSE_CFG   8'h7e
`define WMASK_DEBOUNCE    8'h7f

// sense config fields
`define SC_THR_BIT   6
`define SC_INS_LSB   4
`define SC_COUP_BIT  3
`define SC_DBL_BIT   2
`define SC_EN_BIT    1

// debounce config fields
`define DC_HP_BIT    6
`define DC_INS_LSB   3
`define DC_REM_BIT   2
`define DC_HOOK_LSB  0

// status fields
`define ST_JACK_LSB  6
`define ST_HS_LSB    4

// impedance limits in ohm
`define HOOK_AC_LOW  11'd320
`define MIC_AC_LOW   11'd800
`define HOOK_AC_HIGH 11'd680
`define MIC_AC_HIGH  11'd1350
`define HOOK_DC_LOW  11'd150
`define MIC_DC_HIGH  11'd1750
`define INS_MIN_0    8'd150
`define INS_MIN_1    8'd100
`define INS_MIN_2    8'd50

// timing
`define CLK_KHZ        40000
`define MS_CYCLES      (`CLK_KHZ * 1)
`define PULSE_MS_0     11'd2000
`define PULSE_MS_1     11'd1000
`define PULSE_MS_2     11'd133
`define PULSE_MS_3     11'd66
`define INS_BASE_MS    10'd16
`define INS_NO_DEB     3'd7
`define INS_RESERVED   3'd6
`define REMOVE_CNT_0   3'd5
`define REMOVE_CNT_1   3'd3
`define HP_DEB_CNT     3'd3
`define HOOK_CNT_2     3'd2
`define HOOK_CNT_3     3'd3
`define NO_DEB_CNT     3'd1

`endif

// File: inc/headset_detect_pkg.sv
// Purpose: types shared by the headset detection logic
// Assumes: nothing
// Notes:   structs carry grouped signals
package headset_detect_pkg;

	// comparator results from the analog sense front end
	typedef struct packed {
		logic jack;   // jack sleeve/tip sensed
		logic mic;    // microphone impedance sensed
		logic hook;   // hook button sensed pressed
		logic left;   // left channel load sensed
		logic right;  // right channel load sensed
	} sense_t;

	// settings driven to the analog sense front end
	typedef struct packed {
		logic        sense_on;         // detection powered
		logic        dc_coupled;       // dc coupled detection
		logic        double_current;   // 2x sense current
		logic [10:0] hook_limit_ohm;   // highest hook impedance
		logic [10:0] mic_limit_ohm;    // lowest mic impedance
		logic [7:0]  insert_hook_ohm;  // hook-pressed insertion minimum
	} analog_ctrl_t;

	// jack qualification states
	typedef enum logic [1:0] {
		jack_absent,
		jack_inserting,
		jack_present
	} jack_state_t;

endpackage

// File: design/sense_debounce.sv
// Purpose: qualifies a sampled level after a number of agreeing samples
// Assumes: sample_en_in is a one-cycle strobe per detection
// Notes:   need of 0 or 1 means the first sample is taken at once
`timescale 1ns/1ps
module sense_debounce (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// control
	input  wire logic       clear_in,
	input  wire logic       sample_en_in,
	input  wire logic       sample_in,
	input  wire logic [2:0] need_in,
	// result
	output logic            level_out
);
	logic [2:0] count;       // differing samples against level
	logic [2:0] next_count;
	logic       level;
	logic       next_level;

	// count consecutive samples that differ from the held level
	always_comb begin
		next_count = count;
		next_level = level;
		if (clear_in) begin
			next_count = 3'h0;
			next_level = 1'b0;
		end else if (sample_en_in) begin
			if (sample_in == level) begin
				next_count = 3'h0;   // agreement restarts run
			end else if (count + 3'h1 >= need_in) begin
				next_level = sample_in;   // run complete
				next_count = 3'h0;
			end else begin
				next_count = count + 3'h1;
			end
		end
	end

	// register state
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= 3'h0;
			level <= 1'b0;
		end else begin
			count <= next_count;
			level <= next_level;
		end
	end

	assign level_out = level;
endmodule

// File: design/headset_jack_detect_regs.sv
// Purpose: jack detection configuration, debounce and status registers
// Assumes: register port and sense inputs synchronous to clk_in
// Notes:   status reads zero while detection is off
`timescale 1ns/1ps
`include "headset_detect_cfg.svh"

// What this block does
// - ac coupling: threshold bit picks hook/mic limits
// - dc coupling: hook 150 ohm with threshold bit clear, mic 1750 ohm with it set
// - insertion hook minimum 150/100/50 ohm with resistor type bit clear, 0 with it set
// - coupling bit selects ac or dc detection
// - double sense current when bit set
// - sense enable, off after reset
// - headphone debounce: none or three detections
// - insertion debounce 16 to 512 ms, 7 none
// - removal needs five or three detections
// - hook press debounce none, two, three
// - jack type 0, 1 or 3 only
// - headset channel type none/right/left/stereo
// - detection pulse rate 0.5 to 15 Hz
module headset_jack_detect_regs
	import headset_detect_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES   // clock cycles per millisecond
) (
	// clock and reset
	input  wire logic         clk_in,
	input  wire logic         rst_in,
	// register port
	input  wire logic [7:0]   reg_addr_in,
	input  wire logic         reg_wr_en_in,
	input  wire logic         reg_rd_en_in,
	input  wire logic [7:0]   reg_wdata_in,
	output logic [7:0]        reg_rdata_out,
	// neighbouring configuration
	input  wire logic [1:0]   detect_pulse_rate_in,
	input  wire logic         ext_resistor_type_bit_in,
	// analog sense front end
	input  wire sense_t       sense_in,
	output analog_ctrl_t      analog_ctrl_out,
	output logic              detect_pulse_out,
	output logic              hook_pressed_out
);
	// configuration registers
	logic [7:0]   headset_sense_config;
	logic [7:0]   headset_debounce_config;
	logic [7:0]   next_sense_config;
	logic [7:0]   next_debounce_config;
	logic [7:0]   rdata;
	logic [7:0]   next_rdata;
	// decoded fields
	logic         hook_threshold_select;
	logic [1:0]   hook_insert_min_impedance;
	logic         headphone_coupling_sel;
	logic         double_sense_current;
	logic         headset_sense_enable;
	logic         headphone_debounce_sel;
	logic [2:0]   insertion_debounce_time;
	logic         removal_debounce_count;
	logic [1:0]   hook_press_debounce;
	// timing
	logic [31:0]  ms_count;
	logic [31:0]  next_ms_count;
	logic         ms_tick;
	logic         next_ms_tick;
	logic [10:0]  pulse_ms;
	logic [10:0]  next_pulse_ms;
	logic         pulse;
	logic         next_pulse;
	// jack qualification
	jack_state_t  jack_state;
	jack_state_t  next_jack_state;
	logic [9:0]   ins_ms;
	logic [9:0]   next_ins_ms;
	logic         removed;      // removal run complete
	logic         mic_ok;
	logic         left_ok;
	logic         right_ok;
	logic         hook_ok;
	logic         present;
	logic [2:0]   remove_need;
	logic [2:0]   hp_need;
	logic [2:0]   hook_need;
	// registered outputs
	analog_ctrl_t ctrl;
	analog_ctrl_t next_ctrl;
	logic [1:0]   jack_type;
	logic [1:0]   headset_channel_type;
	logic [1:0]   next_jack_type;
	logic [1:0]   next_channel_type;
	logic         hook_pressed;
	logic         next_hook_pressed;

	// pulse period in ms for a rate code
	function automatic logic [10:0] period_ms(input logic [1:0] code);
		unique case (code)
			2'd0: period_ms = `PULSE_MS_0;
			2'd1: period_ms = `PULSE_MS_1;
			2'd2: period_ms = `PULSE_MS_2;
			2'd3: period_ms = `PULSE_MS_3;
		endcase
	endfunction

	// insertion debounce time in ms for a code, 0 means none
	function automatic logic [9:0] insert_ms(input logic [2:0] code);
		if (code == `INS_NO_DEB) begin
			insert_ms = 10'h0;
		end else if (code == `INS_RESERVED) begin
			insert_ms = `INS_BASE_MS;   // reserved falls back to shortest
		end else begin
			insert_ms = `INS_BASE_MS << code;
		end
	endfunction

	// field decode
	assign hook_threshold_select     = headset_sense_config[`SC_THR_BIT];
	assign hook_insert_min_impedance = headset_sense_config[`SC_INS_LSB +: 2];
	assign headphone_coupling_sel    = headset_sense_config[`SC_COUP_BIT];
	assign double_sense_current      = headset_sense_config[`SC_DBL_BIT];
	assign headset_sense_enable      = headset_sense_config[`SC_EN_BIT];
	assign headphone_debounce_sel    = headset_debounce_config[`DC_HP_BIT];
	assign insertion_debounce_time   = headset_debounce_config[`DC_INS_LSB +: 3];
	assign removal_debounce_count    = headset_debounce_config[`DC_REM_BIT];
	assign hook_press_debounce       = headset_debounce_config[`DC_HOOK_LSB +: 2];

	// register writes and read data
	always_comb begin
		next_sense_config    = headset_sense_config;
		next_debounce_config = headset_debounce_config;
		next_rdata           = rdata;
		if (reg_wr_en_in && reg_addr_in == `ADDR_SENSE_CFG) begin
			next_sense_config = reg_wdata_in & `WMASK_SENSE_CFG;
		end
		if (reg_wr_en_in && reg_addr_in == `ADDR_DEBOUNCE_CFG) begin
			next_debounce_config = reg_wdata_in & `WMASK_DEBOUNCE;
		end
		if (reg_rd_en_in) begin
			unique case (reg_addr_in)
				`ADDR_SENSE_CFG:    next_rdata = headset_sense_config;
				`ADDR_DEBOUNCE_CFG: next_rdata = headset_debounce_config;
				// low nibble reserved, zero
				`ADDR_STATUS:       next_rdata = {jack_type, headset_channel_type, 4'h0};
				default:            next_rdata = 8'h00;
			endcase
		end
	end

	// register storage, detection off after reset
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			headset_sense_config    <= `RST_SENSE_CFG;
			headset_debounce_config <= `RST_DEBOUNCE_CFG;
			rdata                   <= 8'h00;
		end else begin
			headset_sense_config    <= next_sense_config;
			headset_debounce_config <= next_debounce_config;
			rdata                   <= next_rdata;
		end
	end

	// millisecond tick and detection pulse timer, run only when enabled
	always_comb begin
		next_ms_count = ms_count;
		next_ms_tick  = 1'b0;
		next_pulse_ms = pulse_ms;
		next_pulse    = 1'b0;
		if (!headset_sense_enable) begin
			next_ms_count = 32'h0;
			next_pulse_ms = 11'h0;
		end else if (ms_count >= 32'(MS_CYCLES - 1)) begin
			next_ms_count = 32'h0;
			next_ms_tick  = 1'b1;
			// one pulse per period, each pulse one detection
			if (pulse_ms + 11'h1 >= period_ms(detect_pulse_rate_in)) begin
				next_pulse_ms = 11'h0;
				next_pulse    = 1'b1;
			end else begin
				next_pulse_ms = pulse_ms + 11'h1;
			end
		end else begin
			next_ms_count = ms_count + 32'h1;
		end
	end

	// timer registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ms_count <= 32'h0;
			ms_tick  <= 1'b0;
			pulse_ms <= 11'h0;
			pulse    <= 1'b0;
		end else begin
			ms_count <= next_ms_count;
			ms_tick  <= next_ms_tick;
			pulse_ms <= next_pulse_ms;
			pulse    <= next_pulse;
		end
	end

	// detection counts from config
	assign remove_need = removal_debounce_count ? `REMOVE_CNT_1 : `REMOVE_CNT_0;
	assign hp_need     = headphone_debounce_sel ? `HP_DEB_CNT : `NO_DEB_CNT;
	assign hook_need   = (hook_press_debounce == 2'd3) ? `HOOK_CNT_3 :
	                     (hook_press_debounce == 2'd2) ? `HOOK_CNT_2 : `NO_DEB_CNT;
	assign present     = (jack_state == jack_present);

	// removal: run of absent detections while present
	sense_debounce u_removal (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.clear_in     (!present),
		.sample_en_in (pulse),
		.sample_in    (!sense_in.jack),
		.need_in      (remove_need),
		.level_out    (removed)
	);

	// headphone/mic and channel load qualification
	sense_debounce u_mic (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.clear_in     (!present),
		.sample_en_in (pulse),
		.sample_in    (sense_in.mic),
		.need_in      (hp_need),
		.level_out    (mic_ok)
	);
	sense_debounce u_left (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.clear_in     (!present),
		.sample_en_in (pulse),
		.sample_in    (sense_in.left),
		.need_in      (hp_need),
		.level_out    (left_ok)
	);
	sense_debounce u_right (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.clear_in     (!present),
		.sample_en_in (pulse),
		.sample_in    (sense_in.right),
		.need_in      (hp_need),
		.level_out    (right_ok)
	);

	// hook press qualification
	sense_debounce u_hook (
		.clk_in       (clk_in),
		.rst_in       (rst_in),
		.clear_in     (!present),
		.sample_en_in (pulse),
		.sample_in    (sense_in.hook),
		.need_in      (hook_need),
		.level_out    (hook_ok)
	);

	// jack insertion timing and removal
	always_comb begin
		next_jack_state = jack_state;
		next_ins_ms     = ins_ms;
		if (!headset_sense_enable) begin
			next_jack_state = jack_absent;
			next_ins_ms     = 10'h0;
		end else begin
			unique case (jack_state)
				jack_absent: begin
					next_ins_ms = 10'h0;
					if (pulse && sense_in.jack) begin
						next_jack_state = jack_inserting;
					end
				end
				jack_inserting: begin
					if (!sense_in.jack) begin
						next_jack_state = jack_absent;   // bounce restarts
					end else if (ins_ms >= insert_ms(insertion_debounce_time)) begin
						next_jack_state = jack_present;
					end else if (ms_tick) begin
						next_ins_ms = ins_ms + 10'h1;
					end
				end
				jack_present: begin
					if (removed) begin
						next_jack_state = jack_absent;
					end
				end
			endcase
		end
	end

	// jack state registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			jack_state <= jack_absent;
			ins_ms     <= 10'h0;
		end else begin
			jack_state <= next_jack_state;
			ins_ms     <= next_ins_ms;
		end
	end

	// status and analog settings
	always_comb begin
		next_ctrl                = '0;
		next_ctrl.sense_on       = headset_sense_enable;
		next_ctrl.dc_coupled     = headphone_coupling_sel;
		next_ctrl.double_current = double_sense_current;
		if (!hook_threshold_select) begin
			next_ctrl.mic_limit_ohm  = `MIC_AC_LOW;
			next_ctrl.hook_limit_ohm = headphone_coupling_sel ? `HOOK_DC_LOW : `HOOK_AC_LOW;
		end else begin
			next_ctrl.hook_limit_ohm = `HOOK_AC_HIGH;
			next_ctrl.mic_limit_ohm  = headphone_coupling_sel ? `MIC_DC_HIGH : `MIC_AC_HIGH;
		end
		// only meaningful for external resistor type 0
		if (!ext_resistor_type_bit_in) begin
			unique case (hook_insert_min_impedance)
				2'd0:    next_ctrl.insert_hook_ohm = `INS_MIN_0;
				2'd1:    next_ctrl.insert_hook_ohm = `INS_MIN_1;
				2'd2:    next_ctrl.insert_hook_ohm = `INS_MIN_2;
				default: next_ctrl.insert_hook_ohm = `INS_MIN_0;   // reserved code
			endcase
		end
		// status only from qualified state, code 2 never produced
		next_jack_type    = present ? (mic_ok ? 2'd3 : 2'd1) : 2'd0;
		next_channel_type = present ? {left_ok, right_ok} : 2'd0;
		next_hook_pressed = present && hook_ok;
	end

	// output registers
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl                 <= '0;
			jack_type            <= 2'd0;
			headset_channel_type <= 2'd0;
			hook_pressed         <= 1'b0;
		end else begin
			ctrl                 <= next_ctrl;
			jack_type            <= next_jack_type;
			headset_channel_type <= next_channel_type;
			hook_pressed         <= next_hook_pressed;
		end
	end

	// outputs straight from flip-flops
	assign reg_rdata_out    = rdata;
	assign analog_ctrl_out  = ctrl;
	assign detect_pulse_out = pulse;
	assign hook_pressed_out = hook_pressed;
endmodule

// File: bench/headset_jack_detect_regs_checker.sv
// Purpose: concurrent checks on the jack detect register block
// Assumes: bound to the block; one clock domain
// Notes:   shadows mirror the writable register bits
`timescale 1ns/1ps
`include "headset_detect_cfg.svh"
module headset_jack_detect_regs_checker
	import headset_detect_pkg::*;
#(
	parameter int MS_CYCLES = 4  // cycles per ms
) (
	// clock and reset
	input wire logic         clk_in,
	input wire logic         rst_in,
	// register port
	input wire logic [7:0]   reg_addr_in,
	input wire logic         reg_wr_en_in,
	input wire logic         reg_rd_en_in,
	input wire logic [7:0]   reg_wdata_in,
	input wire logic [7:0]   reg_rdata_out,
	// configuration and front end
	input wire logic [1:0]   detect_pulse_rate_in,
	input wire logic         ext_resistor_type_bit_in,
	input wire sense_t       sense_in,
	input wire analog_ctrl_t analog_ctrl_out,
	input wire logic         detect_pulse_out,
	input wire logic         hook_pressed_out
);
	logic [7:0] sc;    // sense config shadow
	logic [7:0] sc_d;  // shadow a cycle later
	logic [7:0] dc;    // debounce config shadow
	logic       live;  // past first edge after reset
	logic       wr_s;  // write to sense config
	logic       wr_d;  // write to debounce config
	assign wr_s = reg_wr_en_in && reg_addr_in == `ADDR_SENSE_CFG;
	assign wr_d = reg_wr_en_in && reg_addr_in == `ADDR_DEBOUNCE_CFG;
	// mirror writes, reserved bits dropped
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			sc   <= 8'h00;
			sc_d <= 8'h00;
			dc   <= 8'h00;
			live <= 1'b0;
		end else begin
			sc   <= wr_s ? reg_wdata_in & `WMASK_SENSE_CFG : sc;
			sc_d <= sc;
			dc   <= wr_d ? reg_wdata_in & `WMASK_DEBOUNCE : dc;
			live <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	a_sense_on_follow: assert property (live |-> analog_ctrl_out.sense_on == sc_d[1])
		else $error("sense enable output wrong");
	a_coupling_follow: assert property (live |-> analog_ctrl_out.dc_coupled == sc_d[3])
		else $error("coupling output wrong");
	a_double_current: assert property (live |-> analog_ctrl_out.double_current == sc_d[2])
		else $error("sense current output wrong");
	a_hook_limit: assert property (live |->
		analog_ctrl_out.hook_limit_ohm == (sc_d[6] ? `HOOK_AC_HIGH : sc_d[3] ? `HOOK_DC_LOW : `HOOK_AC_LOW))
		else $error("hook limit wrong");
	a_mic_limit: assert property (live |->
		analog_ctrl_out.mic_limit_ohm == (sc_d[6] ? (sc_d[3] ? `MIC_DC_HIGH : `MIC_AC_HIGH) : `MIC_AC_LOW))
		else $error("mic limit wrong");
	a_insert_minimum: assert property (live |-> analog_ctrl_out.insert_hook_ohm ==
		($past(ext_resistor_type_bit_in) ? 8'h00 : sc_d[5:4] == 2'h1 ? `INS_MIN_1 :
		sc_d[5:4] == 2'h2 ? `INS_MIN_2 : `INS_MIN_0))
		else $error("insertion hook minimum wrong");
	a_sense_readback: assert property (reg_rd_en_in && reg_addr_in == `ADDR_SENSE_CFG |=>
		reg_rdata_out == $past(sc)) else $error("sense config read wrong");
	a_debounce_readback: assert property (reg_rd_en_in && reg_addr_in == `ADDR_DEBOUNCE_CFG |=>
		reg_rdata_out == $past(dc)) else $error("debounce config read wrong");
	a_status_codes: assert property (reg_rd_en_in && reg_addr_in == `ADDR_STATUS |=>
		reg_rdata_out[3:0] == 4'h0 && reg_rdata_out[7:6] != 2'h2) else $error("status code illegal");
	a_unmapped_zero: assert property (reg_rd_en_in && reg_addr_in > `ADDR_STATUS |=>
		reg_rdata_out == 8'h00) else $error("unmapped read not zero");
	a_disabled_quiet: assert property (!sc[1] [*3] |-> !detect_pulse_out && !hook_pressed_out)
		else $error("activity while detection off");
	c_enable: cover property (wr_s && reg_wdata_in[1]);
	c_hook: cover property ($rose(hook_pressed_out));
	c_mic: cover property (reg_rd_en_in && reg_addr_in == `ADDR_STATUS ##1 reg_rdata_out[7:6] == 2'h3);
endmodule

// File: bench/headset_plug_model.sv
// Purpose: headset on the jack as seen by the sense comparators
// Assumes: bench sets the plug state at the falling edge
// Notes:   unpowered comparators give a pattern that changes every cycle
`timescale 1ns/1ps
module headset_plug_model
	import headset_detect_pkg::*;
#(
	parameter logic [10:0] MIC_OHM = 11'h3e8  // mic element impedance
) (
	// clock and front end settings
	input  wire logic         clk_in,
	input  wire analog_ctrl_t ctrl_in,
	// plug state from the bench
	input  wire logic         plugged_in,
	input  wire logic [1:0]   loads_in,     // {left,right}
	input  wire logic [10:0]  hook_ohm_in,  // 0 when released
	// comparator levels
	output sense_t            sense_out
);
	initial sense_out = 5'h0a;
	// comparators follow the plug only while powered
	always @(posedge clk_in) begin
		if (!ctrl_in.sense_on) begin
			sense_out <= ~sense_out;
		end else begin
			sense_out.jack  <= plugged_in;
			sense_out.mic   <= plugged_in && MIC_OHM >= ctrl_in.mic_limit_ohm;
			sense_out.hook  <= plugged_in && hook_ohm_in != 11'h000 && hook_ohm_in <= ctrl_in.hook_limit_ohm;
			sense_out.left  <= plugged_in && loads_in[1];
			sense_out.right <= plugged_in && loads_in[0];
		end
	end
endmodule

// File: bench/tb_top.sv
// Purpose: self-checking bench for the jack detect register block
// Assumes: 40 MHz clock, four cycles per ms
// Notes:   inputs change at the falling edge
`timescale 1ns/1ps
`include "headset_detect_cfg.svh"
module tb_top
	import headset_detect_pkg::*;
;
	logic         clk;       // 40 MHz clock
	logic         rst;       // async reset
	logic [7:0]   addr;      // register address
	logic         wr_en;     // write strobe
	logic         rd_en;     // read strobe
	logic [7:0]   wdata;     // write data
	logic [7:0]   rdata;     // read data
	logic         ext;       // resistor type
	sense_t       sense;     // comparator levels
	analog_ctrl_t actl;      // front end settings
	logic         pulse;     // detection pulse
	logic         hook;      // hook pressed
	logic         plug;      // jack inserted
	logic [1:0]   loads;     // {left,right}
	logic [10:0]  hook_ohm;  // hook button impedance
	int           mismatches;
	int           compares;
	logic [7:0]   cfgs [5] = '{8'h00, 8'h4c, 8'h52, 8'h28, 8'hff};
	logic [1:0]   rate;      // detection pulse rate code
	logic [10:0]  per_ms [4] = '{`PULSE_MS_0, `PULSE_MS_1, `PULSE_MS_2, `PULSE_MS_3};  // period per rate code
	headset_jack_detect_regs #(.MS_CYCLES(4)) uut (
		.clk_in(clk), .rst_in(rst), .reg_addr_in(addr), .reg_wr_en_in(wr_en),
		.reg_rd_en_in(rd_en), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
		.detect_pulse_rate_in(rate), .ext_resistor_type_bit_in(ext), .sense_in(sense),
		.analog_ctrl_out(actl), .detect_pulse_out(pulse), .hook_pressed_out(hook)
	);
	headset_plug_model pm (
		.clk_in(clk), .ctrl_in(actl), .plugged_in(plug), .loads_in(loads),
		.hook_ohm_in(hook_ohm), .sense_out(sense)
	);
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// count and report one comparison
	task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_en = 1'b1;
		@(negedge clk);
		wr_en = 1'b0;
	endtask
	// one register read and compare
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input string what);
		@(negedge clk);
		addr = a;
		rd_en = 1'b1;
		@(negedge clk);
		rd_en = 1'b0;
		cmp(what, {8'h00, e}, {8'h00, rdata});
	endtask
	// wait for n detection pulses, then let status settle
	task automatic pulses(input int n);
		for (int i = 0; i < n; ) begin
			@(negedge clk);
			if (pulse === 1'b1) begin
				i++;
			end
		end
		repeat (4) @(negedge clk);
	endtask
	// cycles between two detection pulses at one rate code
	task automatic period(input logic [1:0] code, input logic [15:0] exp);
		logic [15:0] n;
		n = 16'h0000;
		rate = code;
		do @(negedge clk); while (pulse !== 1'b1);
		do begin
			@(negedge clk);
			n++;
		end while (pulse !== 1'b1);
		cmp("pulse period", exp, n);
	endtask
	// verdict
	task automatic final_report;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (50000) @(posedge clk);
		mismatches++;
		final_report();
	end
	// main sequence
	initial begin
		{rst, addr, wr_en, rd_en, wdata, ext, plug, loads, hook_ohm, rate} = '0;
		rst = 1'b1;
		mismatches = 0;
		compares = 0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		for (int a = 8'h1a; a < 8'h1e; a++) begin
			rd(8'(a), 8'h00, "reset value");
		end
		foreach (cfgs[i]) begin
			wr(`ADDR_SENSE_CFG, cfgs[i]);
			rd(`ADDR_SENSE_CFG, cfgs[i] & 8'h7e, "sense cfg");
		end
		ext = 1'b1;
		repeat (2) @(negedge clk);
		cmp("ins min ext", 16'h0000, {8'h00, actl.insert_hook_ohm});
		ext = 1'b0;
		wr(`ADDR_DEBOUNCE_CFG, 8'hff);
		rd(`ADDR_DEBOUNCE_CFG, 8'h7f, "debounce cfg");
		wr(`ADDR_STATUS, 8'hff);
		rd(`ADDR_STATUS, 8'h00, "status write");
		// pulse period at every rate code, fastest first
		for (int c = 3; c >= 0; c--) begin
			period(2'(c), {5'h00, per_ms[c]} * 16'd4);
		end
		rate = 2'h3;
		wr(`ADDR_DEBOUNCE_CFG, 8'h06);
		wr(`ADDR_SENSE_CFG, 8'h02);
		pulses(1);
		plug = 1'b1;
		loads = 2'h3;
		pulses(1);
		rd(`ADDR_STATUS, 8'h00, "insert early");
		pulses(2);
		rd(`ADDR_STATUS, 8'hf0, "stereo mic");
		hook_ohm = 11'h0c8;
		pulses(1);
		cmp("hook one", 16'h0000, {15'h0000, hook});
		pulses(1);
		cmp("hook two", 16'h0001, {15'h0000, hook});
		hook_ohm = 11'h000;
		wr(`ADDR_DEBOUNCE_CFG, 8'h46);
		loads = 2'h1;
		pulses(2);
		rd(`ADDR_STATUS, 8'hf0, "mono wait");
		pulses(1);
		rd(`ADDR_STATUS, 8'hd0, "mono right");
		plug = 1'b0;
		pulses(2);
		rd(`ADDR_STATUS, 8'hd0, "removal wait");
		pulses(1);
		rd(`ADDR_STATUS, 8'h00, "removed");
		plug = 1'b1;
		hook_ohm = 11'h0c8;
		pulses(4);
		cmp("hook again", 16'h0001, {15'h0000, hook});
		wr(`ADDR_SENSE_CFG, 8'h00);
		repeat (2) @(negedge clk);
		rd(`ADDR_STATUS, 8'h00, "disabled");
		cmp("hook off", 16'h0000, {15'h0000, hook});
		final_report();
	end
endmodule
bind headset_jack_detect_regs headset_jack_detect_regs_checker #(.MS_CYCLES(MS_CYCLES)) chk (
	.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr_in), .reg_wr_en_in(reg_wr_en_in),
	.reg_rd_en_in(reg_rd_en_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
	.detect_pulse_rate_in(detect_pulse_rate_in), .ext_resistor_type_bit_in(ext_resistor_type_bit_in),
	.sense_in(sense_in), .analog_ctrl_out(analog_ctrl_out), .detect_pulse_out(detect_pulse_out),
	.hook_pressed_out(hook_pressed_out)
);
